/* File: hdl/sac_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - On convert command: hold the sample, start conversion clock, clear approximation register.
// - A started conversion runs to the end; no result is driven meanwhile.
// - Bits are trialled MSB first; kept if DAC sum below input, else cleared.
// - At end of convert: stop clock, back to sample, delay busy fall.
// - Reads are accepted during the acquisition tail before busy falls.
// - Control pins act only with chip enable high and select low.
// - With both active, read_convert high reads and low converts.
// - byte_select sampled at start: low gives 12-bit, high gives 8-bit conversion.
// - Word width high drives all twelve bits; low gives two bytes.
// - Byte read: byte_select low gives eight MSBs, high gives four LSBs.
// - Low byte holds four LSBs in upper nibble, lower nibble zeros.
// - Stand-alone: buffers on while read_convert high and idle or in the acquisition tail; conversion on each fall while idle.
// - Low pulse: outputs float at the fall, valid again after conversion.
// - Busy rises 200 ns after the fall, falls 1 us after data valid.
// - High pulse: data driven while high, floating from the fall onward.
// - Busy rises for a conversion and falls at the end of its cycle.
// - Start commands during a conversion cycle are ignored.
// - Buffers enabled by a read early in the acquisition tail are on at least 0.6 us before busy falls.
// - Bipolar result is offset binary; the comparator decides every code alike.
//////////////////////////////////////////////////////////////////////////////
package sac_pkg;

  // Timing, in nanoseconds and derived cycles.
  localparam int CLK_PERIOD_NS = 4;
  localparam int BUSY_RISE_NS  = 200;
  localparam int BUSY_RISE_CYC = (BUSY_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAIL_NS       = 1000;
  localparam int TAIL_CYC      = (TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_NS       = 640;
  localparam int STEP_CYC      = STEP_NS / CLK_PERIOD_NS;
  localparam int OE_LEAD_NS    = 600;
  localparam int OE_LEAD_CYC   = (OE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 8;

  // Result layout.
  localparam int RESULT_W       = 12;
  localparam int NIBBLE_W       = 4;
  localparam int IDX_W          = 4;
  localparam logic [IDX_W-1:0] MSB_IDX        = 4'hb;
  localparam logic [IDX_W-1:0] FULL_LAST_IDX  = 4'h0;
  localparam logic [IDX_W-1:0] SHORT_LAST_IDX = 4'h4;
  localparam logic [RESULT_W-1:0] SAR_MSB_MASK = 12'h800;
  localparam logic [RESULT_W-1:0] BYTE_OE_MASK = 12'hff0;

  // Register map.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h08;
  localparam int CTRL_PIN_EN_BIT     = 0;
  localparam int CTRL_SOFT_START_BIT = 1;
  localparam int CTRL_SOFT_SHORT_BIT = 2;
  localparam logic CTRL_PIN_EN_RESET = 1'b1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_SHORT_BIT  = 1;
  localparam int STAT_ACTIVE_BIT = 2;
  localparam int STAT_STATE_LSB  = 4;

  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SETTLE = 2'b01,
    SAC_TRIAL  = 2'b11,
    SAC_ACQ    = 2'b10
  } sacState_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } sacApbReq_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sacApbRsp_t;

  typedef struct packed {
    logic chipEnable;
    logic deviceSelect_n;
    logic readConvert;
    logic wordWidth;
    logic byteSelect;
  } sacPins_t;

endpackage

/* File: hdl/sac_conv_ctrl.sv */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module sac_conv_ctrl (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // APB slave
  input  wire sac_pkg::sacApbReq_t           apbReq,
  output sac_pkg::sacApbRsp_t                apbRsp,
  // Host control pins
  input  wire sac_pkg::sacPins_t             pins,
  // Result lines, split three-state
  output logic [sac_pkg::RESULT_W-1:0]       resultLines,
  output logic [sac_pkg::RESULT_W-1:0]       resultLinesOe,
  output logic                               conversionBusy,
  // Analog front end
  input  wire logic                          compAbove,
  output logic                               trackHold,
  output logic                               convClockEn,
  output logic [sac_pkg::RESULT_W-1:0]       dacCode
);
  import sac_pkg::*;

  sacState_t           state_q;
  logic [TIMER_W-1:0]  timer_q;
  logic [IDX_W-1:0]    bitIdx_q;
  logic [RESULT_W-1:0] sar_q;
  logic [RESULT_W-1:0] sar_d;
  logic [RESULT_W-1:0] result_q;
  logic                short_q;
  logic                convCmd_q;
  logic                pinEn_q;
  logic                softStart_q;
  logic                softShort_q;
  logic [31:0]         prdata_q;
  logic                slvErr_q;
  logic [RESULT_W-1:0] lines_d;
  logic [RESULT_W-1:0] oe_d;
  logic                pinsActive;
  logic                convCmd;
  logic                readCmd;
  logic                start;
  logic                startShort;
  logic                timerDone;
  logic                lastBit;
  logic                eoc;
  logic                apbSetup;
  logic                apbWrite;

  //////////////////////////////////////////////////////////////////////////////
  // Pin decode.

  assign pinsActive = pinEn_q && pins.chipEnable && !pins.deviceSelect_n;
  assign convCmd    = pinsActive && !pins.readConvert;
  assign readCmd    = pinsActive && pins.readConvert;
  // A start is the moment the convert condition appears, whichever pin made it.
  // A command held low does not retrigger; a new edge is needed.
  assign start      = (state_q == SAC_IDLE)
                      && ((convCmd && !convCmd_q) || softStart_q);
  assign startShort = softStart_q ? softShort_q : pins.byteSelect;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      convCmd_q <= 1'b0;
    else
      convCmd_q <= convCmd;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  assign timerDone = (state_q == SAC_SETTLE) ? (timer_q == TIMER_W'(BUSY_RISE_CYC - 1))
                   : (state_q == SAC_TRIAL)  ? (timer_q == TIMER_W'(STEP_CYC - 1))
                   : (timer_q == TIMER_W'(TAIL_CYC - 1));
  assign lastBit   = bitIdx_q == (short_q ? SHORT_LAST_IDX : FULL_LAST_IDX);
  assign eoc       = (state_q == SAC_TRIAL) && timerDone && lastBit;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= SAC_IDLE;
      timer_q <= '0;
    end
    else
    begin
      case (state_q)
        SAC_IDLE:
        begin
          timer_q <= '0;
          if (start)
            state_q <= SAC_SETTLE;
        end
        SAC_SETTLE:
        begin
          timer_q <= timerDone ? '0 : TIMER_W'(timer_q + 1'b1);
          if (timerDone)
            state_q <= SAC_TRIAL;
        end
        SAC_TRIAL:
        begin
          timer_q <= timerDone ? '0 : TIMER_W'(timer_q + 1'b1);
          if (eoc)
            state_q <= SAC_ACQ;
        end
        SAC_ACQ:
        begin
          timer_q <= timerDone ? '0 : TIMER_W'(timer_q + 1'b1);
          if (timerDone)
            state_q <= SAC_IDLE;
        end
        default:
        begin
          state_q <= SAC_IDLE;
          timer_q <= '0;
        end
      endcase
    end
  end

  // Busy covers the bit trials and the acquisition tail only.
  assign conversionBusy = (state_q == SAC_TRIAL) || (state_q == SAC_ACQ);
  assign trackHold      = (state_q == SAC_SETTLE) || (state_q == SAC_TRIAL);
  assign convClockEn    = trackHold;
  assign dacCode        = sar_q;

  //////////////////////////////////////////////////////////////////////////////
  // Approximation register.

  always_comb
  begin
    sar_d = sar_q;
    if (compAbove)
      sar_d[bitIdx_q] = 1'b0;
    if (!lastBit)
      sar_d[IDX_W'(bitIdx_q - 1'b1)] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sar_q    <= '0;
      bitIdx_q <= MSB_IDX;
      short_q  <= 1'b0;
      result_q <= '0;
    end
    else
    begin
      if (start)
      begin
        sar_q    <= '0;
        bitIdx_q <= MSB_IDX;
        short_q  <= startShort;
      end
      else if (state_q == SAC_SETTLE && timerDone)
        sar_q <= SAR_MSB_MASK;
      else if (state_q == SAC_TRIAL && timerDone)
      begin
        sar_q <= sar_d;
        if (!lastBit)
          bitIdx_q <= IDX_W'(bitIdx_q - 1'b1);
      end
      if (eoc)
        result_q <= sar_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffers. Registered so the lines never glitch while the pins settle,
  // at the cost of one cycle of read latency.

  always_comb
  begin
    lines_d = '0;
    oe_d    = '0;
    // A register start in the same cycle wins, so no stale read outlives it.
    if (readCmd && !start && (state_q == SAC_IDLE || state_q == SAC_ACQ))
    begin
      if (pins.wordWidth)
      begin
        oe_d    = '1;
        lines_d = result_q;
      end
      else if (!pins.byteSelect)
      begin
        oe_d    = BYTE_OE_MASK;
        lines_d = result_q & BYTE_OE_MASK;
      end
      else
      begin
        oe_d    = BYTE_OE_MASK;
        lines_d = {result_q[NIBBLE_W-1:0], {(2 * NIBBLE_W){1'b0}}};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resultLines   <= '0;
      resultLinesOe <= '0;
    end
    else
    begin
      resultLines   <= lines_d;
      resultLinesOe <= oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states; read data is taken in the setup cycle.

  assign apbSetup = apbReq.psel && !apbReq.penable;
  assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pinEn_q     <= CTRL_PIN_EN_RESET;
      softStart_q <= 1'b0;
      softShort_q <= 1'b0;
    end
    else
    begin
      softStart_q <= 1'b0;
      if (apbWrite && apbReq.paddr == CTRL_OFS)
      begin
        pinEn_q     <= apbReq.pwdata[CTRL_PIN_EN_BIT];
        softStart_q <= apbReq.pwdata[CTRL_SOFT_START_BIT];
        softShort_q <= apbReq.pwdata[CTRL_SOFT_SHORT_BIT];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata_q <= '0;
      slvErr_q <= 1'b0;
    end
    else if (apbSetup)
    begin
      prdata_q <= '0;
      slvErr_q <= 1'b0;
      case (apbReq.paddr)
        CTRL_OFS:
        begin
          prdata_q[CTRL_PIN_EN_BIT]     <= pinEn_q;
          prdata_q[CTRL_SOFT_SHORT_BIT] <= softShort_q;
        end
        STATUS_OFS:
        begin
          prdata_q[STAT_BUSY_BIT]                    <= conversionBusy;
          prdata_q[STAT_SHORT_BIT]                   <= short_q;
          prdata_q[STAT_ACTIVE_BIT]                  <= state_q != SAC_IDLE;
          prdata_q[STAT_STATE_LSB+1:STAT_STATE_LSB]  <= state_q;
        end
        RESULT_OFS:
          prdata_q[RESULT_W-1:0] <= result_q;
        default:
          slvErr_q <= 1'b1;
      endcase
    end
  end

  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = slvErr_q && apbReq.psel && apbReq.penable;
  assign apbRsp.prdata  = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  localparam int RiseCyc = BUSY_RISE_CYC;
  localparam int TailCyc = TAIL_CYC;
  localparam int LeadCyc = OE_LEAD_CYC;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sStart;
    start;
  endsequence

  sequence sEndTrials;
    eoc;
  endsequence

  a_start_holds: assert property (sStart |=> trackHold && convClockEn && sar_q == '0)
    else $error("conversion start did not hold, clock and clear");
  a_no_data_conv: assert property ((state_q == SAC_SETTLE || state_q == SAC_TRIAL)
    |-> resultLinesOe == '0)
    else $error("result driven during conversion");
  a_busy_rise: assert property (sStart |=> !conversionBusy ##RiseCyc conversionBusy)
    else $error("busy did not rise after the settle delay");
  a_busy_tail: assert property (sEndTrials |-> ##TailCyc conversionBusy
    ##1 !conversionBusy)
    else $error("busy fall not delayed by the acquisition tail");
  a_ignore_start: assert property ((state_q == SAC_TRIAL) && convCmd && !convCmd_q
    |=> state_q == SAC_TRIAL || state_q == SAC_ACQ)
    else $error("start accepted during conversion");
  a_tail_read: assert property (sEndTrials ##1 (readCmd && pins.wordWidth)[*2]
    |=> resultLinesOe == '1 && resultLines == result_q)
    else $error("read refused during acquisition tail");
  a_oe_lead: assert property (sEndTrials ##1 (readCmd && pins.wordWidth)[*2]
    |-> ##(TailCyc - LeadCyc) conversionBusy && resultLinesOe == '1)
    else $error("buffers not on well before busy falls");
  a_low_byte: assert property ($past(readCmd && !pins.wordWidth && pins.byteSelect
    && state_q == SAC_IDLE) |-> resultLines[2*NIBBLE_W-1:0] == '0
    && resultLines[RESULT_W-1:2*NIBBLE_W] == result_q[NIBBLE_W-1:0])
    else $error("low byte packing wrong");
  a_high_byte: assert property ($past(readCmd && !pins.wordWidth && !pins.byteSelect
    && state_q == SAC_IDLE) |-> resultLinesOe == BYTE_OE_MASK)
    else $error("high byte enables wrong");
  a_deselect: assert property (!(pins.chipEnable && !pins.deviceSelect_n)
    |=> resultLinesOe == '0)
    else $error("buffers on while deselected");
  a_msb_first: assert property ((state_q == SAC_TRIAL) && timerDone && !lastBit
    |=> bitIdx_q == IDX_W'($past(bitIdx_q) - 1'b1))
    else $error("bit trials out of order");
  a_trial_keep: assert property ((state_q == SAC_TRIAL) && timerDone && !compAbove
    |=> sar_q[$past(bitIdx_q)])
    else $error("kept bit was cleared");
  a_last_bit: assert property (sEndTrials
    |-> bitIdx_q == (short_q ? SHORT_LAST_IDX : FULL_LAST_IDX))
    else $error("wrong conversion length");

endmodule

/* File: test/sac_comparator_model.sv */
`timescale 1ns/100ps
module sac_comparator_model (
  // Approximation code from the block
  input  wire logic [sac_pkg::RESULT_W-1:0] dacCode,
  // Held input level, expressed as a code
  input  wire logic [sac_pkg::RESULT_W-1:0] analogCode,
  // Comparator decision, high when the DAC sum is above the input
  output logic                              compAbove
);
  import sac_pkg::*;
  // An exact match counts as below, so the last trial bit of a matching code stays set.
  assign compAbove = (dacCode > analogCode);
endmodule

/* File: test/sar_adc_conversion_control_tb.sv */
`timescale 1ns/100ps
module sar_adc_conversion_control_tb;
  import sac_pkg::*;
  logic                clk;
  logic                rst_n;
  sacApbReq_t          apbReq;
  sacApbRsp_t          apbRsp;
  sacPins_t            pins;
  logic [RESULT_W-1:0] resultLines;
  logic [RESULT_W-1:0] resultLinesOe;
  logic                conversionBusy;
  logic                compAbove;
  logic                trackHold;
  logic                convClockEn;
  logic [RESULT_W-1:0] dacCode;
  logic [RESULT_W-1:0] analogCode;
  int                  numErrors;
  int                  numChecks;
  logic [31:0]         rd;
  logic                err;
  int                  n;

  sac_conv_ctrl sac_conv_ctrl_i (
    .clk            (clk),
    .rst_n          (rst_n),
    .apbReq         (apbReq),
    .apbRsp         (apbRsp),
    .pins           (pins),
    .resultLines    (resultLines),
    .resultLinesOe  (resultLinesOe),
    .conversionBusy (conversionBusy),
    .compAbove      (compAbove),
    .trackHold      (trackHold),
    .convClockEn    (convClockEn),
    .dacCode        (dacCode)
  );

  sac_comparator_model sac_comparator_model_i (
    .dacCode    (dacCode),
    .analogCode (analogCode),
    .compAbove  (compAbove)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic endOfTest;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    numErrors++;
    $display("wrong value %s expected done seen timeout", what);
    endOfTest();
  endtask

  // Bounded waits only; a hang ends the run through the closing report.
  task automatic waitBusy(input logic lvl, output int cnt);
    cnt = 0;
    while (conversionBusy !== lvl)
    begin
      @(posedge clk);
      cnt++;
      if (cnt > 5000)
        timeout("busy wait");
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdata, output logic rerr);
    int k;
    k = 0;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (apbRsp.pready !== 1'b1 && k < 50);
    if (k >= 50)
      timeout("pready wait");
    rdata = apbRsp.prdata;
    rerr  = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  // Select low is held, so the read-or-convert line and enable pick the operation.
  task automatic startConv(input logic shortConv);
    @(posedge clk);
    pins.chipEnable  <= 1'b0;
    pins.readConvert <= 1'b0;
    pins.byteSelect  <= shortConv;
    @(posedge clk);
    pins.chipEnable <= 1'b1;
  endtask

  // Enable is dropped with the read so that no convert edge follows it.
  task automatic readPins(input logic ww, input logic bs, output logic [11:0] lines,
                          output logic [11:0] oe);
    @(posedge clk);
    pins <= '{chipEnable: 1'b1, deviceSelect_n: 1'b0, readConvert: 1'b1,
              wordWidth: ww, byteSelect: bs};
    repeat (2) @(posedge clk);
    #1;
    lines = resultLines & resultLinesOe;
    oe    = resultLinesOe;
    @(posedge clk);
    pins.chipEnable <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic runConv(input logic [11:0] code, input logic shortConv);
    logic [11:0] exp;
    logic [11:0] lines;
    logic [11:0] oe;
    int          cnt;
    exp = shortConv ? (code & 12'hff0) : code;
    analogCode <= code;
    startConv(shortConv);
    waitBusy(1'b1, cnt);
    check("busy rise delay", (cnt >= 50 && cnt <= 54), 1);
    readPins(1'b1, 1'b0, lines, oe);
    check("oe during conversion", oe, 12'h000);
    startConv(1'b0);
    cnt = 0;
    while (trackHold !== 1'b0)
    begin
      @(posedge clk);
      cnt++;
      if (cnt > 5000)
        timeout("end of convert wait");
    end
    check("busy in acquisition", conversionBusy, 1'b1);
    readPins(1'b1, 1'b0, lines, oe);
    check("word read", lines, exp);
    check("word oe", oe, 12'hfff);
    waitBusy(1'b0, cnt);
    check("oe lead over busy fall", (cnt >= 150 && cnt <= 251), 1);
    readPins(1'b0, 1'b0, lines, oe);
    check("high byte", lines, exp & 12'hff0);
    check("high byte oe", oe, 12'hff0);
    readPins(1'b0, 1'b1, lines, oe);
    check("low byte", lines, {exp[3:0], 8'h00});
    check("low byte oe", oe, 12'hff0);
    apb(1'b0, RESULT_OFS, 32'h0, rd, err);
    check("result register", rd, {20'h0, exp});
    repeat (100) @(posedge clk);
    check("no second conversion", conversionBusy, 1'b0);
    $display("test conversion %h short %b done", code, shortConv);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    numErrors  = 0;
    numChecks  = 0;
    rst_n      = 1'b0;
    analogCode = 12'h000;
    apbReq     = '0;
    pins       = '{chipEnable: 1'b0, deviceSelect_n: 1'b0, readConvert: 1'b1,
                   wordWidth: 1'b1, byteSelect: 1'b0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("busy after reset", conversionBusy, 1'b0);
    check("oe after reset", resultLinesOe, 12'h000);
    apb(1'b0, CTRL_OFS, 32'h0, rd, err);
    check("control reset", rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test reset and map done");
    runConv(12'h5a3, 1'b0);
    runConv(12'h7ff, 1'b0);
    runConv(12'h800, 1'b0);
    runConv(12'hc3e, 1'b1);
    // Deselected device must ignore a convert level; the select line then starts it.
    @(posedge clk);
    pins.deviceSelect_n <= 1'b1;
    pins.readConvert    <= 1'b0;
    pins.byteSelect     <= 1'b0;
    analogCode          <= 12'h3c5;
    @(posedge clk);
    pins.chipEnable <= 1'b1;
    repeat (80) @(posedge clk);
    check("busy while deselected", conversionBusy, 1'b0);
    pins.deviceSelect_n <= 1'b0;
    waitBusy(1'b1, n);
    waitBusy(1'b0, n);
    apb(1'b0, RESULT_OFS, 32'h0, rd, err);
    check("select started result", rd, 32'h3c5);
    $display("test select start done");
    @(posedge clk);
    pins.chipEnable <= 1'b0;
    analogCode      <= 12'h9a6;
    apb(1'b1, CTRL_OFS, 32'h3, rd, err);
    waitBusy(1'b1, n);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    check("status busy", rd[STAT_BUSY_BIT], 1'b1);
    waitBusy(1'b0, n);
    apb(1'b0, RESULT_OFS, 32'h0, rd, err);
    check("soft start result", rd, 32'h9a6);
    apb(1'b0, CTRL_OFS, 32'h0, rd, err);
    check("control readback", rd, 32'h1);
    $display("test register start done");
    // Stand-alone wiring: only the read-or-convert line moves.
    @(posedge clk);
    pins       <= '{chipEnable: 1'b1, deviceSelect_n: 1'b0, readConvert: 1'b1,
                    wordWidth: 1'b1, byteSelect: 1'b0};
    analogCode <= 12'h1e7;
    repeat (4) @(posedge clk);
    #1;
    check("stand-alone oe high", resultLinesOe, 12'hfff);
    @(posedge clk);
    pins.readConvert <= 1'b0;
    repeat (2) @(posedge clk);
    pins.readConvert <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("stand-alone oe in conversion", resultLinesOe, 12'h000);
    waitBusy(1'b1, n);
    waitBusy(1'b0, n);
    #1;
    check("stand-alone data", resultLines, 12'h1e7);
    check("stand-alone data oe", resultLinesOe, 12'hfff);
    $display("test stand-alone done");
    endOfTest();
  end
endmodule
